// >>> hdl/spsp_port.sv
// Serial peripheral port: master or slave, 3-wire or 4-wire
`timescale 1ns/1ps
module spsp_port
   import spsp_pkg::*;
#(
   parameter int SCK_HALF = SCK_HALF_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ctrl_wr,
   input wire spsp_ctrl_t ctrl_wdata,
   input wire logic data_wr,
   input wire logic [7:0] data_wdata,
   input wire logic done_clr,
   input wire logic fault_clr,
   input wire spsp_pin_t pins_in,
   output spsp_ctrl_t ctrl_state,
   output logic [7:0] port_data_reg,
   output logic transfer_done_flag,
   output logic mode_fault_flag,
   output logic busy,
   output logic irq,
   output spsp_pin_t pins_out,
   output spsp_pin_t pins_oe
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   spsp_ctrl_t ctrl_reg;
   spsp_state_t state_reg;
   spsp_state_t state_next;
   spsp_pin_t pins_s;
   spsp_pin_t out_reg;
   spsp_pin_t oe_reg;
   logic [7:0] shift_reg;
   logic [7:0] rx_buf_reg;
   logic [2:0] bit_cnt_reg;
   logic [7:0] div_reg;
   logic done_reg;
   logic mode_fault_flag_reg;
   logic irq_reg;
   logic sck_d_reg;
   logic slave_act_d_reg;
   logic busy_reg;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   spsp_sync #(
      .WIDTH($bits(spsp_pin_t))
   ) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .async_in(pins_in),
      .reset_level(RST_PIN),
      .sync_out(pins_s)
   );

   // ------------------------------------------------------------
   // Mode decode
   // ------------------------------------------------------------
   // multi-master decode
   wire mode_multi = !ctrl_reg.select_mode_hi && ctrl_reg.select_mode_lo;
   wire mode_four = ctrl_reg.select_mode_hi;
   wire master_run = ctrl_reg.port_enable_bit && ctrl_reg.master_enable_bit;
   wire fault_set = master_run && mode_multi && !pins_s.slave_select;
   wire slave_act = ctrl_reg.port_enable_bit && !ctrl_reg.master_enable_bit && !pins_s.slave_select;
   wire slave_start = slave_act && !slave_act_d_reg;
   wire sck_rise = pins_s.sck && !sck_d_reg;
   wire sck_fall = !pins_s.sck && sck_d_reg;

   // ------------------------------------------------------------
   // Half period divider; only runs while master is shifting
   // ------------------------------------------------------------
   wire div_tick = (div_reg == 8'(SCK_HALF - 1));
   wire [7:0] div_next = (state_reg == ST_IDLE || div_tick) ? 8'h00 : div_reg + 8'h01;

   // ------------------------------------------------------------
   // Master sequencer decode
   // ------------------------------------------------------------
   wire m_start = master_run && !fault_set && (state_reg == ST_IDLE) && data_wr;
   wire m_sample = (state_reg == ST_LOW) && div_tick;
   wire m_shift = (state_reg == ST_HIGH) && div_tick;
   wire m_last = m_shift && (bit_cnt_reg == 3'h0);
   wire s_sample = slave_act && sck_rise;
   wire s_last = s_sample && (bit_cnt_reg == 3'h7);
   wire s_load = !slave_act && !master_run && data_wr;

   // Shift input comes from the far end in either role
   wire sample_bit = master_run ? pins_s.miso : pins_s.mosi;
   wire do_sample = m_sample || s_sample;
   // incoming bits enter at the LSB end
   wire [7:0] shift_in = {shift_reg[6:0], sample_bit};
   wire [7:0] shift_next = m_start ? data_wdata :
                           s_load ? data_wdata :
                           do_sample ? shift_in : shift_reg;

   // Master counts rising edges; slave counts sampled edges
   wire [2:0] cnt_next = (m_start || (!slave_act && !master_run)) ? 3'h0 :
                         do_sample ? bit_cnt_reg + 3'h1 : bit_cnt_reg;

   wire done_set = m_last || s_last;
   wire done_next = done_set || (done_reg && !done_clr);
   wire mode_fault_flag_next = fault_set || (mode_fault_flag_reg && !fault_clr);

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (m_start) begin
               state_next = ST_LOW;
            end
         end
         ST_LOW: begin
            if (!master_run) begin
               state_next = ST_IDLE;
            end else if (div_tick) begin
               state_next = ST_HIGH;
            end
         end
         ST_HIGH: begin
            if (!master_run || m_last) begin
               state_next = ST_IDLE;
            end else if (div_tick) begin
               state_next = ST_LOW;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Control bits
   // ------------------------------------------------------------
   // fault clears enables; no self restore
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= RST_CTRL;
      end else if (fault_set) begin
         ctrl_reg.master_enable_bit <= 1'b0;
         ctrl_reg.port_enable_bit <= 1'b0;
      end else if (ctrl_wr) begin
         ctrl_reg <= ctrl_wdata;
      end
   end

   // ------------------------------------------------------------
   // Shift path, counters, flags
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         div_reg <= 8'h00;
         shift_reg <= RST_BYTE;
         bit_cnt_reg <= 3'h0;
         sck_d_reg <= 1'b0;
         slave_act_d_reg <= 1'b0;
         busy_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         div_reg <= div_next;
         shift_reg <= shift_next;
         bit_cnt_reg <= cnt_next;
         sck_d_reg <= pins_s.sck;
         slave_act_d_reg <= slave_act;
         // Registered so the busy pin is glitch free
         busy_reg <= (state_next != ST_IDLE);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_buf_reg <= RST_BYTE;
      end else if (m_last) begin
         rx_buf_reg <= shift_reg;
      end else if (s_last) begin
         rx_buf_reg <= shift_in;
      end
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         done_reg <= 1'b0;
         mode_fault_flag_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         done_reg <= done_next;
         mode_fault_flag_reg <= mode_fault_flag_next;
         irq_reg <= ctrl_reg.int_enable && (done_reg || mode_fault_flag_reg);
      end
   end

   // ------------------------------------------------------------
   // Pin drives
   // ------------------------------------------------------------
   // data out changes on the falling side
   wire mosi_next = m_start ? data_wdata[7] : m_shift ? shift_reg[7] : out_reg.mosi;
   wire miso_next = (slave_start || (slave_act && sck_fall)) ? shift_reg[7] : out_reg.miso;
   wire sck_next = (state_next == ST_HIGH);
   // select level is the lower mode bit
   wire ss_next = ctrl_reg.select_mode_lo;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_reg <= RST_PIN;
         oe_reg <= RST_OE;
      end else begin
         out_reg <= '{sck_next, mosi_next, miso_next, ss_next};
         // select drive only in four wire master
         oe_reg <= '{master_run, master_run, slave_act, master_run && mode_four};
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign ctrl_state = ctrl_reg;
   assign port_data_reg = rx_buf_reg;
   assign transfer_done_flag = done_reg;
   assign mode_fault_flag = mode_fault_flag_reg;
   assign busy = busy_reg;
   assign irq = irq_reg;
   assign pins_out = out_reg;
   assign pins_oe = oe_reg;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   // Counts master clock rises within one byte
   logic [3:0] chk_rises_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         chk_rises_reg <= 4'h0;
      end else if (m_start) begin
         chk_rises_reg <= 4'h0;
      end else if (m_sample) begin
         chk_rises_reg <= chk_rises_reg + 4'h1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_FAULT_FLAG: assert property (fault_set |=> mode_fault_flag)
      else $error("mode fault not flagged");
   AST_FAULT_DISABLES: assert property (fault_set |=> !ctrl_state.master_enable_bit
                                        && !ctrl_state.port_enable_bit)
      else $error("enables kept after mode fault");
   AST_IRQ_GATE: assert property (irq |-> $past(ctrl_state.int_enable)
                                  && $past(transfer_done_flag || mode_fault_flag))
      else $error("interrupt without enabled cause");
   AST_SS_FOLLOWS: assert property (master_run && mode_four |=> pins_oe.slave_select
                                    && pins_out.slave_select == $past(ctrl_reg.select_mode_lo))
      else $error("select output wrong in four wire mode");
   // no select drive in three wire
   AST_THREE_WIRE: assert property (!ctrl_reg.select_mode_hi && !ctrl_reg.select_mode_lo
                                    |=> !pins_oe.slave_select)
      else $error("select driven in three wire mode");
   AST_EIGHT_CLOCKS: assert property (m_last |-> chk_rises_reg == 4'h8)
      else $error("byte finished without eight clocks");
   AST_MSB_FIRST: assert property (m_start |=> pins_out.mosi == $past(data_wdata[7])
                                   ##[1:64] pins_out.sck)
      else $error("master did not lead with MSB");
   AST_RX_LOAD: assert property (s_last |=> port_data_reg == $past(shift_in)
                                 && transfer_done_flag)
      else $error("slave byte not buffered");
   // done flag set by master end
   // Back to back starts are legal, so only the first idle cycle is checked
   AST_DONE_SET: assert property (m_last |=> transfer_done_flag && !busy)
      else $error("master end without done flag");
   AST_SLAVE_DRIVE: assert property (slave_act |=> pins_oe.miso)
      else $error("selected slave not driving");

   COV_MASTER_BYTE: cover property (m_start ##[1:200] m_last);
   // Cycles since the slave was selected, saturating; an outside clock is slow
   logic [10:0] chk_slave_cyc_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         chk_slave_cyc_reg <= 11'h000;
      end else if (slave_start) begin
         chk_slave_cyc_reg <= 11'h000;
      end else if (chk_slave_cyc_reg != 11'h7FF) begin
         chk_slave_cyc_reg <= chk_slave_cyc_reg + 11'h001;
      end
   end

   COV_SLAVE_BYTE: cover property (s_last && chk_slave_cyc_reg < 11'h7D0);
   COV_FAULT: cover property (fault_set ##1 mode_fault_flag);
   COV_FOUR_WIRE: cover property (master_run && mode_four && m_start);

endmodule : spsp_port

// >>> hdl/spsp_pkg.sv
// Shared types and constants for the serial port block
package spsp_pkg;

   // ------------------------------------------------------------
   // Reset values of the control bits
   // ------------------------------------------------------------
   localparam logic RST_INT_ENABLE = 1'b0;
   localparam logic RST_MASTER_ENABLE = 1'b0;
   localparam logic RST_PORT_ENABLE = 1'b0;
   localparam logic RST_SELECT_MODE_HI = 1'b0;
   localparam logic RST_SELECT_MODE_LO = 1'b1;

   // ------------------------------------------------------------
   // Shift geometry and timing
   // ------------------------------------------------------------
   localparam int BYTE_BITS = 8;
   localparam logic [7:0] RST_BYTE = 8'h00;
   // Serial clock half period in ns, and in system clock cycles
   localparam int SCK_HALF_NS = 32;
   localparam int CLK_PERIOD_NS = 8;
   localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Synchroniser depth for pins
   localparam int SYNC_STAGES = 2;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   // Control bits as software sees them
   typedef struct packed {
      logic int_enable;
      logic master_enable_bit;
      logic port_enable_bit;
      logic select_mode_hi;
      logic select_mode_lo;
   } spsp_ctrl_t;

   // One bit per bus line, used for levels, drives and enables
   typedef struct packed {
      logic sck;
      logic mosi;
      logic miso;
      logic slave_select;
   } spsp_pin_t;

   // Master shift sequencer
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LOW = 2'b01,
      ST_HIGH = 2'b10
   } spsp_state_t;

   localparam spsp_ctrl_t RST_CTRL = '{RST_INT_ENABLE, RST_MASTER_ENABLE, RST_PORT_ENABLE,
                                      RST_SELECT_MODE_HI, RST_SELECT_MODE_LO};
   localparam spsp_pin_t RST_PIN = '{1'b0, 1'b0, 1'b0, 1'b1};
   localparam spsp_pin_t RST_OE = '{1'b0, 1'b0, 1'b0, 1'b0};

endpackage : spsp_pkg

// >>> hdl/spsp_sync.sv
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module spsp_sync
   import spsp_pkg::*;
#(
   parameter int WIDTH = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   input wire logic [WIDTH-1:0] reset_level,
   output logic [WIDTH-1:0] sync_out
);

   // ------------------------------------------------------------
   // Per-bit flop pair; first stage feeds only the second
   // ------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_bit
         logic meta_reg;
         logic stable_reg;
         // Reset to idle level so no false edge at release
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               meta_reg <= 1'b0;
               stable_reg <= 1'b0;
            end else begin
               meta_reg <= async_in[gi] ^ reset_level[gi];
               stable_reg <= meta_reg;
            end
         end
         assign sync_out[gi] = stable_reg ^ reset_level[gi];
      end
   endgenerate

endmodule : spsp_sync

// >>> testbench/spsp_far_slave.sv
// Far-side slave model that answers the port when it runs as master
`timescale 1ns/1ps
module spsp_far_slave (
   input wire logic sel_n,
   input wire logic sck,
   input wire logic mosi,
   input wire logic [7:0] tx_byte,
   output logic miso,
   output logic [7:0] rx_byte
);
   logic [7:0] sh_reg;
   initial begin
      sh_reg = 8'h00;
      rx_byte = 8'h00;
      miso = 1'b1;
   end
   // Load reply, first bit out at select
   always @(negedge sel_n) begin
      sh_reg = tx_byte;
      miso = tx_byte[7];
   end
   // Next bit after each falling clock
   always @(negedge sck) begin
      if (!sel_n) begin
         sh_reg = {sh_reg[6:0], 1'b0};
         miso = sh_reg[7];
      end
   end
   // Master bits captured on the rising clock
   always @(posedge sck) begin
      if (!sel_n) rx_byte = {rx_byte[6:0], mosi};
   end
   // Released line shows the inverse, so a stale bit never passes
   always @(posedge sel_n) miso = ~miso;
endmodule : spsp_far_slave

// >>> testbench/spi_master_slave_port_tb.sv
// Self-checking bench for the serial port block
`timescale 1ns/1ps
module spi_master_slave_port_tb import spsp_pkg::*;;
   localparam int HALF = 4;
   typedef struct packed {
      logic hi;
      logic lo;
      logic gp_n;
      logic [7:0] tx;
      logic [7:0] sx;
      logic [1:0] ss;
   } spsp_row_t;
   // Mode bits, extra select, byte out, byte back, select enable and level
   spsp_row_t rows [4] = '{'{1'b0, 1'b1, 1'b0, 8'hA5, 8'h3C, 2'h1}, '{1'b0, 1'b0, 1'b0, 8'h81, 8'h7E, 2'h1},
                          '{1'b1, 1'b0, 1'b1, 8'h5A, 8'hC9, 2'h2}, '{1'b1, 1'b1, 1'b0, 8'hFF, 8'h01, 2'h3}};
   logic clk, rst_n, ctrl_wr, data_wr, done_clr, fault_clr;
   logic b_sck, b_mosi, b_ss, gp_n, far_miso;
   logic [7:0] data_wdata, far_tx, far_rx, got, port_data_reg;
   logic [7:0] sb = 8'h6D;
   logic transfer_done_flag, mode_fault_flag, busy, irq;
   spsp_ctrl_t ctrl_wdata, ctrl_state;
   spsp_pin_t pins_in, pins_out, pins_oe;
   int fails = 0;
   int comparisons = 0;
   int cnt;

   // Each line carries the design's drive when enabled, else the outside party
   assign pins_in = {pins_oe.sck ? pins_out.sck : b_sck, pins_oe.mosi ? pins_out.mosi : b_mosi,
                     pins_oe.miso ? pins_out.miso : far_miso,
                     pins_oe.slave_select ? pins_out.slave_select : b_ss};

   spsp_port #(.SCK_HALF(HALF)) spsp_port_i (.clk(clk), .rst_n(rst_n), .ctrl_wr(ctrl_wr),
      .ctrl_wdata(ctrl_wdata), .data_wr(data_wr), .data_wdata(data_wdata), .done_clr(done_clr),
      .fault_clr(fault_clr), .pins_in(pins_in), .ctrl_state(ctrl_state), .port_data_reg(port_data_reg),
      .transfer_done_flag(transfer_done_flag), .mode_fault_flag(mode_fault_flag), .busy(busy), .irq(irq),
      .pins_out(pins_out), .pins_oe(pins_oe));
   // Far slave picked by a general purpose line or the select pin
   spsp_far_slave spsp_far_slave_i (.sel_n(gp_n & pins_in.slave_select), .sck(pins_in.sck),
      .mosi(pins_in.mosi), .tx_byte(far_tx), .miso(far_miso), .rx_byte(far_rx));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check

   task automatic pulse_ctrl(input spsp_ctrl_t c);
      @(negedge clk);
      ctrl_wdata = c;
      ctrl_wr = 1'b1;
      @(negedge clk);
      ctrl_wr = 1'b0;
      @(negedge clk);
   endtask : pulse_ctrl

   task automatic start_byte(input logic [7:0] d);
      @(negedge clk);
      data_wdata = d;
      data_wr = 1'b1;
      @(negedge clk);
      data_wr = 1'b0;
   endtask : start_byte

   // Bounded wait for the done flag, returns cycles waited
   task automatic wait_done(output int n);
      n = 0;
      while (transfer_done_flag !== 1'b1 && n < 400) begin
         @(negedge clk);
         n++;
      end
      if (n >= 400) fails++;
   endtask : wait_done

   task automatic complete_run;
      $display("comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : complete_run

   // Whole run needs about 650 cycles; allow over ten times that
   initial begin
      #100000;
      fails++;
      complete_run();
   end

   initial begin
      {rst_n, ctrl_wr, data_wr, done_clr, fault_clr, b_sck, b_mosi} = '0;
      {b_ss, gp_n} = 2'b11;
      ctrl_wdata = '0;
      data_wdata = 8'h00;
      far_tx = 8'h00;
      got = 8'h00;
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      check({ctrl_state, pins_out, pins_oe, port_data_reg, transfer_done_flag, mode_fault_flag, busy, irq},
            {RST_CTRL, RST_PIN, RST_OE, RST_BYTE, 4'h0});
      $display("test reset done");
      foreach (rows[i]) begin
         gp_n = 1'b1;
         pulse_ctrl(5'h00);
         far_tx = rows[i].sx;
         pulse_ctrl({3'b011, rows[i].hi, rows[i].lo});
         gp_n = rows[i].gp_n;
         check({pins_oe.slave_select, pins_out.slave_select | ~pins_oe.slave_select}, rows[i].ss);
         start_byte(rows[i].tx);
         repeat (6) @(negedge clk);
         // Second write lands while busy and must be dropped
         start_byte(~rows[i].tx);
         wait_done(cnt);
         // Flag shows 16 half periods after the start; the wait began 8 cycles in
         check(cnt, 16 * HALF - 8);
         check(port_data_reg, rows[i].sx);
         check(far_rx, rows[i].tx);
         check(busy, 1'b0);
         done_clr = 1'b1;
         @(negedge clk);
         done_clr = 1'b0;
         $display("test row %0d done", i);
      end
      // Select low aborts a running master
      for (int ie = 0; ie < 2; ie++) begin
         pulse_ctrl({ie[0], 4'b1101});
         start_byte(8'h96);
         repeat (10) @(negedge clk);
         b_ss = 1'b0;
         repeat (6) @(negedge clk);
         check({mode_fault_flag, ctrl_state.master_enable_bit, ctrl_state.port_enable_bit, irq}, {3'b100, ie[0]});
         b_ss = 1'b1;
         repeat (80) @(negedge clk);
         check({transfer_done_flag, busy, ctrl_state}, {2'b00, ie[0], 4'b0001});
         fault_clr = 1'b1;
         @(negedge clk);
         fault_clr = 1'b0;
         @(negedge clk);
         check({mode_fault_flag, irq}, 2'b00);
         $display("test fault %0d done", ie);
      end
      // Slave byte under an outside 125 ns clock
      gp_n = 1'b1;
      pulse_ctrl(5'h05);
      start_byte(8'hC3);
      b_ss = 1'b0;
      repeat (4) @(negedge clk);
      check(pins_oe.miso, 1'b1);
      for (int b = 7; b >= 0; b--) begin
         b_mosi = sb[b];
         #62.5 b_sck = 1'b1;
         got = {got[6:0], pins_out.miso};
         #62.5 b_sck = 1'b0;
      end
      wait_done(cnt);
      check(port_data_reg, sb);
      check(got, 8'hC3);
      b_ss = 1'b1;
      b_mosi = ~b_mosi;
      $display("test slave done");
      complete_run();
   end
endmodule : spi_master_slave_port_tb
